// File: gyrfc_pkg.sv
// package: register map, field layout, filter table and timing counts of the rate filter config
package gyrfc_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_Z_OFFSET_HIGH = 8'h17;
  localparam logic [7:0] IDX_Z_OFFSET_LOW  = 8'h18;
  localparam logic [7:0] IDX_RATE_DIVIDER  = 8'h19;
  localparam logic [7:0] IDX_CONFIG        = 8'h1a;
  localparam logic [7:0] IDX_GYRO_CONFIG   = 8'h1b;
  localparam logic [7:0] IDX_STATUS        = 8'h40;
  localparam logic [7:0] IDX_FIFO_DATA     = 8'h41;
  localparam logic [7:0] IDX_FILTER_INFO   = 8'h42;

  // field positions
  localparam int CFG_POLICY_BIT  = 6;
  localparam int CFG_SYNC_LSB    = 3;
  localparam int CFG_LOWPASS_LSB = 0;
  localparam int GCFG_BYPASS_LSB = 0;
  localparam int INFO_RATE_LSB   = 14;
  localparam int INFO_TEMP_LSB   = 16;

  // reset values
  localparam logic [7:0] OFFSET_RESET  = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [6:0] CONFIG_RESET  = 7'h00;
  localparam logic [1:0] BYPASS_RESET  = 2'h0;

  // timing: internal rates in Hz, periods in mclk cycles (rounded down)
  localparam int CLOCK_HZ     = 50_000_000;
  localparam int RATE_1K_HZ   = 1_000;
  localparam int RATE_8K_HZ   = 8_000;
  localparam int RATE_32K_HZ  = 32_000;
  localparam int CYCLES_1K    = CLOCK_HZ / RATE_1K_HZ;
  localparam int CYCLES_8K    = CLOCK_HZ / RATE_8K_HZ;
  localparam int CYCLES_32K   = CLOCK_HZ / RATE_32K_HZ;

  // lowpass settings that keep the 8 kHz rate
  localparam logic [2:0] LOWPASS_WIDE_LOW  = 3'h0;
  localparam logic [2:0] LOWPASS_WIDE_HIGH = 3'h7;

  // gyro 3 dB bandwidths in Hz
  localparam logic [13:0] GYRO_BW_BYPASS0 = 14'h1fed;
  localparam logic [13:0] GYRO_BW_BYPASS1 = 14'h0cd1;
  localparam logic [13:0] GYRO_BW_TABLE [8] = '{14'h00fa, 14'h00b0, 14'h005c, 14'h0029,
                                                 14'h0014, 14'h000a, 14'h0005, 14'h0cd1};
  // temperature 3 dB bandwidths in Hz
  localparam logic [12:0] TEMP_BW_WIDE  = 13'h0fa0;
  localparam logic [12:0] TEMP_BW_TABLE [8] = '{13'h0fa0, 13'h00bc, 13'h0062, 13'h002a,
                                                13'h0014, 13'h000a, 13'h0005, 13'h0fa0};

  // internal sample rate of the gyro path
  typedef enum logic [1:0] {RATE_1K, RATE_8K, RATE_32K} gyrfc_rate_type;
endpackage : gyrfc_pkg

// File: gyrfc_sample_mem.sv
// small sample memory with a registered read port
`timescale 1ns/1ps
module gyrfc_sample_mem #(
  parameter int WIDTH  = 16,
  parameter int DEPTH  = 16,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  // read port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [WIDTH-1:0]  rdData
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] rdData_reg;
  logic [WIDTH-1:0] rdData_next;

  // storage carries no reset, only the read register does
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // read register follows the address one cycle later
  always_comb begin
    rdData_next = store[rdAddr];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
endmodule : gyrfc_sample_mem

// File: gyrfc_rate_filter_config.sv
// rate filter configuration: offset, rate divider, sync latch, fifo policy, filter select
// Behaviour
// (RL1) hold low byte of Z offset
// (RL2) add Z offset to gyro Z sample
// (RL3) sample rate is internal over one plus divider
// (RL4) divider input rate is 1 kHz
// (RL5) divider only with bypass zero, setting 1..6
// (RL6) policy one: full fifo drops new samples
// (RL7) policy zero: full fifo overwrites oldest
// (RL8) sync select places sync in bit 0
// (RL9) sync latch holds until strobe captures
// (RL10) lowpass setting used only without bypass
// (RL11) bypass bits select 32 kHz wide paths
// (RL12) rates and bandwidths per lowpass setting
// (RL13) bypass bits sit at gyro config [1:0]
// (RL14) host writes zero to config bit 7
// (RL15) strobe updates outputs and pushes fifo
`timescale 1ns/1ps
module gyrfc_rate_filter_config #(
  parameter int FIFO_DEPTH = 16,
  parameter int CYCLES_1K  = gyrfc_pkg::CYCLES_1K,
  parameter int CYCLES_8K  = gyrfc_pkg::CYCLES_8K,
  parameter int CYCLES_32K = gyrfc_pkg::CYCLES_32K
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // sync pin from outside
  input  wire logic        frameSyncPin,
  // raw samples from the sensor front end
  input  wire logic [15:0] rawTemp,
  input  wire logic [15:0] rawGyroX,
  input  wire logic [15:0] rawGyroY,
  input  wire logic [15:0] rawGyroZ,
  input  wire logic [15:0] rawAccelX,
  input  wire logic [15:0] rawAccelY,
  input  wire logic [15:0] rawAccelZ,
  // sensor output registers
  output logic      [15:0] tempData,
  output logic      [15:0] rateXData,
  output logic      [15:0] rateYData,
  output logic      [15:0] rateZData,
  output logic      [15:0] accelXData,
  output logic      [15:0] accelYData,
  output logic      [15:0] accelZData,
  // filter control towards the sensor path
  output logic             sampleStrobe,
  output logic             lowpassActive,
  output logic      [1:0]  internalRate,
  output logic      [13:0] gyroBandwidthHz,
  output logic      [12:0] tempBandwidthHz
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);

  // register state
  logic [7:0]  offsetHigh_reg, offsetHigh_next;
  logic [7:0]  offsetLow_reg, offsetLow_next;
  logic [7:0]  divider_reg, divider_next;
  logic [6:0]  config_reg, config_next;
  logic [1:0]  bypass_reg, bypass_next;
  logic        busAck_reg, busAck_next;
  logic [31:0] readdata_reg, readdata_next;
  logic [31:0] readMux;
  logic [7:0]  regIndex;
  logic        wrHit, rdPop;

  // rate and strobe state
  logic [15:0] baseCount_reg, baseCount_next;
  logic [7:0]  divCount_reg, divCount_next;
  logic        strobe_reg, strobe_next;
  logic        baseTick, divEffective;
  logic [15:0] basePeriod;
  gyrfc_pkg::gyrfc_rate_type rateSel;
  logic [13:0] gyroBw_reg, gyroBw_next;
  logic [12:0] tempBw_reg, tempBw_next;
  logic [1:0]  rate_reg, rate_next;

  // sync pin state
  logic [2:0]  pinSync_reg;
  logic        pinStable_reg, pinStable_next;
  logic        pinSeen_reg, pinSeen_next;
  logic        syncLatched_reg, syncLatched_next;
  logic        syncPending_reg, syncPending_next;
  logic        pinToggle;

  // fifo state
  logic [AW-1:0] wrPtr_reg, wrPtr_next;
  logic [AW-1:0] rdPtr_reg, rdPtr_next;
  logic [CW-1:0] count_reg, count_next;
  logic          memWrEn, fullEff, overwrite;
  logic [15:0]   memRdData;

  // sample path
  logic [15:0] userOffset, sumZ;
  logic [15:0] chanRaw [7];
  logic [15:0] chanOut [7];
  logic [15:0] chanNext [7];
  logic [2:0]  syncSel;
  logic [2:0]  lowpassSetting;
  logic        fifoPolicy;

  assign syncSel        = config_reg[gyrfc_pkg::CFG_SYNC_LSB +: 3];
  assign lowpassSetting = config_reg[gyrfc_pkg::CFG_LOWPASS_LSB +: 3];
  assign fifoPolicy     = config_reg[gyrfc_pkg::CFG_POLICY_BIT];

  // bus: one wait state on every access, so read data can come from a flop
  assign regIndex    = address[9:2];
  assign waitrequest = (read | write) & ~busAck_reg;
  assign wrHit       = write & busAck_reg & byteenable[0];
  assign rdPop       = read & busAck_reg & (regIndex == gyrfc_pkg::IDX_FIFO_DATA)
                       & (count_reg != '0);

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    readMux = 32'h0000_0000;
    case (regIndex)
      gyrfc_pkg::IDX_Z_OFFSET_HIGH: readMux[7:0] = offsetHigh_reg;
      gyrfc_pkg::IDX_Z_OFFSET_LOW:  readMux[7:0] = offsetLow_reg;
      gyrfc_pkg::IDX_RATE_DIVIDER:  readMux[7:0] = divider_reg;
      gyrfc_pkg::IDX_CONFIG:        readMux[6:0] = config_reg;
      gyrfc_pkg::IDX_GYRO_CONFIG:   readMux[1:0] = bypass_reg;
      gyrfc_pkg::IDX_STATUS:        readMux = {20'h0_0000, 3'h0, syncPending_reg,
                                               syncLatched_reg, 2'h0, CW'(count_reg)};
      gyrfc_pkg::IDX_FIFO_DATA:     readMux[15:0] = memRdData;
      gyrfc_pkg::IDX_FILTER_INFO:   readMux = {3'h0, tempBw_reg, rate_reg, gyroBw_reg};
      default:                      readMux = 32'h0000_0000;
    endcase
  end

  // register writes take effect at the edge where waitrequest is low
  always_comb begin
    offsetHigh_next = offsetHigh_reg;
    offsetLow_next  = offsetLow_reg;
    divider_next    = divider_reg;
    config_next     = config_reg;
    bypass_next     = bypass_reg;
    busAck_next     = (read | write) & ~busAck_reg;
    readdata_next   = (read & ~busAck_reg) ? readMux : readdata_reg;
    if (wrHit) begin
      case (regIndex)
        gyrfc_pkg::IDX_Z_OFFSET_HIGH: offsetHigh_next = writedata[7:0];
        // (RL1) low offset byte
        gyrfc_pkg::IDX_Z_OFFSET_LOW:  offsetLow_next = writedata[7:0];
        gyrfc_pkg::IDX_RATE_DIVIDER:  divider_next = writedata[7:0];
        // (RL14) bit 7 not stored
        gyrfc_pkg::IDX_CONFIG:        config_next = writedata[6:0];
        // (RL13) bypass in bits 1:0
        gyrfc_pkg::IDX_GYRO_CONFIG:   bypass_next = writedata[gyrfc_pkg::GCFG_BYPASS_LSB +: 2];
        default:                      offsetLow_next = offsetLow_reg;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      offsetHigh_reg <= gyrfc_pkg::OFFSET_RESET;
      offsetLow_reg  <= gyrfc_pkg::OFFSET_RESET;
      divider_reg    <= gyrfc_pkg::DIVIDER_RESET;
      config_reg     <= gyrfc_pkg::CONFIG_RESET;
      bypass_reg     <= gyrfc_pkg::BYPASS_RESET;
      busAck_reg     <= 1'b0;
      readdata_reg   <= 32'h0000_0000;
    end else begin
      offsetHigh_reg <= offsetHigh_next;
      offsetLow_reg  <= offsetLow_next;
      divider_reg    <= divider_next;
      config_reg     <= config_next;
      bypass_reg     <= bypass_next;
      busAck_reg     <= busAck_next;
      readdata_reg   <= readdata_next;
    end
  end
  assign readdata = readdata_reg;

  // filter selection; bit 0 of bypass wins over bit 1
  always_comb begin
    lowpassActive = (bypass_reg == 2'h0);
    if (bypass_reg[0]) begin
      // (RL11) widest path
      rateSel     = gyrfc_pkg::RATE_32K;
      gyroBw_next = gyrfc_pkg::GYRO_BW_BYPASS0;
      tempBw_next = gyrfc_pkg::TEMP_BW_WIDE;
    end else if (bypass_reg[1]) begin
      // (RL11) second wide path
      rateSel     = gyrfc_pkg::RATE_32K;
      gyroBw_next = gyrfc_pkg::GYRO_BW_BYPASS1;
      tempBw_next = gyrfc_pkg::TEMP_BW_WIDE;
    end else begin
      // (RL10) (RL12) table by setting
      rateSel     = (lowpassSetting == gyrfc_pkg::LOWPASS_WIDE_LOW ||
                     lowpassSetting == gyrfc_pkg::LOWPASS_WIDE_HIGH) ?
                    gyrfc_pkg::RATE_8K : gyrfc_pkg::RATE_1K;
      gyroBw_next = gyrfc_pkg::GYRO_BW_TABLE[lowpassSetting];
      tempBw_next = gyrfc_pkg::TEMP_BW_TABLE[lowpassSetting];
    end
    rate_next = rateSel;
    case (rateSel)
      gyrfc_pkg::RATE_32K: basePeriod = 16'(CYCLES_32K);
      gyrfc_pkg::RATE_8K:  basePeriod = 16'(CYCLES_8K);
      // (RL4) 1 kHz divider input
      gyrfc_pkg::RATE_1K:  basePeriod = 16'(CYCLES_1K);
      default:             basePeriod = 16'(CYCLES_1K);
    endcase
  end

  // (RL5) divider only in the 1 kHz lowpass range
  assign divEffective = lowpassActive && (lowpassSetting != gyrfc_pkg::LOWPASS_WIDE_LOW)
                        && (lowpassSetting != gyrfc_pkg::LOWPASS_WIDE_HIGH);
  // wrap with >= so a shorter period after a mode change does not stall the count
  assign baseTick = (baseCount_reg >= basePeriod - 16'h0001);

  // (RL3) divide internal ticks by one plus divider
  always_comb begin
    baseCount_next = baseTick ? 16'h0000 : baseCount_reg + 16'h0001;
    divCount_next  = divCount_reg;
    strobe_next    = 1'b0;
    if (baseTick) begin
      if (!divEffective || divCount_reg >= divider_reg) begin
        strobe_next   = 1'b1;
        divCount_next = 8'h00;
      end else begin
        divCount_next = divCount_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      baseCount_reg <= 16'h0000;
      divCount_reg  <= 8'h00;
      strobe_reg    <= 1'b0;
      gyroBw_reg    <= 14'h0000;
      tempBw_reg    <= 13'h0000;
      rate_reg      <= 2'h0;
    end else begin
      baseCount_reg <= baseCount_next;
      divCount_reg  <= divCount_next;
      strobe_reg    <= strobe_next;
      gyroBw_reg    <= gyroBw_next;
      tempBw_reg    <= tempBw_next;
      rate_reg      <= rate_next;
    end
  end
  assign sampleStrobe    = strobe_reg;
  assign gyroBandwidthHz = gyroBw_reg;
  assign tempBandwidthHz = tempBw_reg;
  assign internalRate    = rate_reg;

  // sync pin: three flops, a change counts once stages two and three agree
  assign pinToggle = (pinStable_reg != pinSeen_reg) && !syncPending_reg;

  // (RL9) toggle once, then hold until the strobe takes it
  always_comb begin
    pinStable_next   = (pinSync_reg[1] == pinSync_reg[2]) ? pinSync_reg[2] : pinStable_reg;
    pinSeen_next     = pinSeen_reg;
    syncLatched_next = syncLatched_reg;
    syncPending_next = syncPending_reg & ~strobe_reg;
    if (pinToggle) begin
      pinSeen_next     = pinStable_reg;
      syncLatched_next = ~syncLatched_reg;
      syncPending_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pinSync_reg     <= 3'h0;
      pinStable_reg   <= 1'b0;
      pinSeen_reg     <= 1'b0;
      syncLatched_reg <= 1'b0;
      syncPending_reg <= 1'b0;
    end else begin
      pinSync_reg     <= {pinSync_reg[1:0], frameSyncPin};
      pinStable_reg   <= pinStable_next;
      pinSeen_reg     <= pinSeen_next;
      syncLatched_reg <= syncLatched_next;
      syncPending_reg <= syncPending_next;
    end
  end

  // (RL2) full sixteen-bit offset added, wrapping
  assign userOffset = {offsetHigh_reg, offsetLow_reg};
  assign sumZ       = rawGyroZ + userOffset;
  assign chanRaw[0] = rawTemp;
  assign chanRaw[1] = rawGyroX;
  assign chanRaw[2] = rawGyroY;
  assign chanRaw[3] = sumZ;
  assign chanRaw[4] = rawAccelX;
  assign chanRaw[5] = rawAccelY;
  assign chanRaw[6] = rawAccelZ;

  // one output register per channel, loaded on the strobe
  for (genvar ch = 0; ch < 7; ch++) begin : g_chan
    logic [15:0] out_reg, out_next;
    // (RL8) (RL15) sync bit replaces bit 0
    always_comb begin
      out_next = out_reg;
      if (strobe_reg) begin
        out_next = chanRaw[ch];
        if (syncSel == 3'(ch + 1)) begin
          out_next[0] = syncLatched_reg;
        end
      end
    end
    always_ff @(posedge mclk) begin
      if (reset) begin
        out_reg <= 16'h0000;
      end else begin
        out_reg <= out_next;
      end
    end
    assign chanOut[ch] = out_reg;
    // the fifo takes the value being loaded, not the one it replaces
    assign chanNext[ch] = out_next;
  end
  assign tempData   = chanOut[0];
  assign rateXData  = chanOut[1];
  assign rateYData  = chanOut[2];
  assign rateZData  = chanOut[3];
  assign accelXData = chanOut[4];
  assign accelYData = chanOut[5];
  assign accelZData = chanOut[6];

  // fifo of offset-corrected gyro Z; a pop in the same cycle frees a slot
  assign fullEff   = (count_reg == FULL_COUNT) && !rdPop;
  // (RL6) (RL7) policy decides drop or overwrite
  assign memWrEn   = strobe_reg && (!fullEff || !fifoPolicy);
  assign overwrite = strobe_reg && fullEff && !fifoPolicy;

  always_comb begin
    wrPtr_next = memWrEn ? wrPtr_reg + AW'(1) : wrPtr_reg;
    rdPtr_next = (rdPop || overwrite) ? rdPtr_reg + AW'(1) : rdPtr_reg;
    count_next = count_reg + CW'(memWrEn && !fullEff) - CW'(rdPop);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  gyrfc_sample_mem #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_mem (
    .mclk   (mclk),
    .reset  (reset),
    .wrEn   (memWrEn),
    .wrAddr (wrPtr_reg),
    .wrData (chanNext[3]),
    .rdAddr (rdPtr_reg),
    .rdData (memRdData)
  );

  // checks on the logic above
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_z_offset_sum: assert property (strobe_reg && syncSel != 3'h4 |=> rateZData == $past(sumZ)) // RL2
    else $error("gyro Z output is not raw plus offset");
  a_low_offset_write: assert property (wrHit && regIndex == gyrfc_pkg::IDX_Z_OFFSET_LOW
      |=> userOffset[7:0] == $past(writedata[7:0])) // RL1
    else $error("low offset byte not written");
  a_divider_bypassed: assert property (baseTick && !divEffective |=> strobe_reg) // RL5
    else $error("tick without strobe while divider ignored");
  a_strobe_on_tick: assert property (strobe_reg |-> $past(baseTick)) // RL3
    else $error("strobe without internal tick");
  a_divider_skip: assert property (divEffective && baseTick && divCount_reg < divider_reg
      |=> !strobe_reg) // RL3
    else $error("strobe before divider count reached");
  a_fifo_discard: assert property (strobe_reg && fullEff && fifoPolicy
      |=> count_reg == $past(count_reg) && wrPtr_reg == $past(wrPtr_reg)) // RL6
    else $error("full fifo accepted a write under drop policy");
  a_fifo_overwrite: assert property (strobe_reg && fullEff && !fifoPolicy
      |=> count_reg == FULL_COUNT && rdPtr_reg == $past(rdPtr_reg) + AW'(1)) // RL7
    else $error("full fifo did not overwrite oldest");
  a_sync_insert: assert property (strobe_reg && syncSel == 3'h1
      |=> tempData[0] == $past(syncLatched_reg)) // RL8
    else $error("sync bit not placed in temperature");
  a_sync_hold: assert property (syncPending_reg && !strobe_reg
      |=> $stable(syncLatched_reg)) // RL9
    else $error("sync latch moved before capture");
  a_bypass_rate: assert property (bypass_reg != 2'h0 |-> !lowpassActive
      ##1 rate_reg == 2'(gyrfc_pkg::RATE_32K)) // RL10
    else $error("bypass did not select 32 kHz");
  a_wide_setting: assert property (bypass_reg == 2'h0 && lowpassSetting == 3'h7
      |=> rate_reg == 2'(gyrfc_pkg::RATE_8K) && gyroBw_reg == 14'h0cd1) // RL12
    else $error("setting 7 rate or bandwidth wrong");
  a_bus_wait: assert property ((read || write) && !busAck_reg |=> !waitrequest ##1 1'b1)
    else $error("bus access not answered after one wait");

  c_overwrite: cover property (overwrite);
  c_discard: cover property (strobe_reg && fullEff && fifoPolicy);
  c_sync_insert: cover property (strobe_reg && syncPending_reg && syncSel != 3'h0);
  c_divided: cover property (divEffective && divider_reg != 8'h00 && strobe_reg);
endmodule : gyrfc_rate_filter_config

// File: test_gyro_rate_filter_config.sv
// testbench: register access, filter table, rate divider, sync latch and fifo policy
`timescale 1ns/1ps
module test_gyro_rate_filter_config;
  // short internal periods keep the run small
  localparam int C1K  = 40;
  localparam int C8K  = 20;
  localparam int C32K = 10;
  logic        mclk, reset, read, write, waitrequest, frameSyncPin, sampleStrobe, lowpassActive;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, rd, ex;
  logic [3:0]  byteenable;
  logic [15:0] rawTemp, rawGyroX, rawGyroY, rawGyroZ, rawAccelX, rawAccelY, rawAccelZ;
  logic [15:0] tempData, rateZData, k;
  logic [15:0] rateXData, rateYData, accelXData, accelYData, accelZData;
  logic [6:0]  syncBits;
  logic [1:0]  internalRate;
  logic [13:0] gyroBandwidthHz;
  logic [12:0] tempBandwidthHz;
  logic [13:0] gyroBw [8] = '{14'h00fa, 14'h00b0, 14'h005c, 14'h0029,
                              14'h0014, 14'h000a, 14'h0005, 14'h0cd1};
  logic [12:0] tempBw [8] = '{13'h0fa0, 13'h00bc, 13'h0062, 13'h002a,
                              13'h0014, 13'h000a, 13'h0005, 13'h0fa0};
  int          nMismatch = 0;
  int          nTests    = 0;
  int          c, ep;

  gyrfc_rate_filter_config #(.FIFO_DEPTH(16), .CYCLES_1K(C1K), .CYCLES_8K(C8K),
                             .CYCLES_32K(C32K)) uut (
    .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .frameSyncPin(frameSyncPin), .rawTemp(rawTemp),
    .rawGyroX(rawGyroX), .rawGyroY(rawGyroY), .rawGyroZ(rawGyroZ), .rawAccelX(rawAccelX),
    .rawAccelY(rawAccelY), .rawAccelZ(rawAccelZ), .tempData(tempData),
    .rateXData(rateXData), .rateYData(rateYData), .rateZData(rateZData),
    .accelXData(accelXData), .accelYData(accelYData), .accelZData(accelZData),
    .sampleStrobe(sampleStrobe), .lowpassActive(lowpassActive), .internalRate(internalRate),
    .gyroBandwidthHz(gyroBandwidthHz), .tempBandwidthHz(tempBandwidthHz));

  // clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // raw samples follow a strobe counter, so fifo entries reveal their order
  always @(posedge mclk) begin
    if (sampleStrobe === 1'b1) begin
      rawGyroZ <= rawGyroZ + 16'h0001;
    end
  end
  // temperature keeps bit 0 clear so the inserted sync bit is visible
  assign rawTemp   = {rawGyroZ[14:0], 1'b0};
  assign rawGyroX  = ~rawGyroZ;
  assign rawGyroY  = rawGyroZ ^ 16'h5a5a;
  assign rawAccelX = rawGyroZ + 16'h0100;
  assign rawAccelY = rawGyroZ + 16'h0200;
  assign rawAccelZ = rawGyroZ + 16'h0300;
  // bit 0 of every output, temperature first, for the sync placement checks
  assign syncBits  = {accelZData[0], accelYData[0], accelXData[0], rateZData[0],
                      rateYData[0], rateXData[0], tempData[0]};

  task finish_test;
    $display("checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; the request stands until waitrequest is sampled low
  // a wait that never ends is left to the watchdog
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    read      <= ~wr;
    write     <= wr;
    address   <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // wait for the next strobe; c counts edges in between, k is the captured raw count
  task wstr;
    c = 0;
    @(posedge mclk);
    while (sampleStrobe !== 1'b1) begin
      @(posedge mclk);
      c++;
    end
    k = rawGyroZ;
  endtask : wstr

  task per(input int exp);
    repeat (3) wstr;
    chk(c + 1, exp);
  endtask : per

  // watchdog, well beyond the expected run of some five thousand cycles
  initial begin
    #800000;
    nMismatch++;
    finish_test;
  end

  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = 10'h000; writedata = 32'h0;
    byteenable = 4'hf; frameSyncPin = 1'b0; rawGyroZ = 16'h0000;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    // reset values, unmapped place, all seven stored config bits
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h18 + 8'(i), 8'h00);
      chk(rd, 32'h0);
    end
    bus(1'b1, 8'h30, 8'h5a);
    bus(1'b0, 8'h30, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, 8'h1a, 8'h7f);
    bus(1'b0, 8'h1a, 8'h00);
    chk(rd, 32'h7f);
    bus(1'b1, 8'h18, 8'h05);
    bus(1'b1, 8'h17, 8'hff);
    bus(1'b1, 8'h19, 8'h02);
    bus(1'b0, 8'h18, 8'h00);
    chk(rd, 32'h05);
    bus(1'b0, 8'h19, 8'h00);
    chk(rd, 32'h02);
    $display("test registers done");
    // short sync pulse is held until a strobe takes it into temperature bit 0
    bus(1'b1, 8'h1a, 8'h08);
    wstr;
    frameSyncPin <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    frameSyncPin <= 1'b0;
    wstr;
    repeat (2) @(posedge mclk);
    chk(tempData, {k[14:0], 1'b1});
    // every other select: the pulse lands in bit 0 of its own output only
    for (int sel = 2; sel < 8; sel++) begin
      bus(1'b1, 8'h1a, 8'(sel * 8));
      wstr;
      frameSyncPin <= 1'b1;
      repeat (2) @(posedge mclk);
      frameSyncPin <= 1'b0;
      wstr;
      repeat (2) @(posedge mclk);
      ex = {25'h0, k[0], k[0], k[0], ~k[0], k[0], ~k[0], 1'b0};
      ex[sel - 1] = 1'b1;
      chk({25'h0, syncBits}, ex);
    end
    bus(1'b1, 8'h1a, 8'h00);
    repeat (2) wstr;
    repeat (2) @(posedge mclk);
    chk(tempData, {k[14:0], 1'b0});
    $display("test sync done");
    // every bypass and lowpass setting: info register, filter flag, strobe period
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 8; s++) begin
        bus(1'b1, 8'h1b, 8'(b));
        bus(1'b1, 8'h1a, 8'(s));
        bus(1'b0, 8'h42, 8'h00);
        if (b == 0) begin
          ex = {3'h0, tempBw[s], (s == 0 || s == 7) ? 2'h1 : 2'h0, gyroBw[s]};
          ep = (s == 0 || s == 7) ? C8K : 3 * C1K;
        end else begin
          ex = {3'h0, 13'h0fa0, 2'h2, (b % 2 == 1) ? 14'h1fed : 14'h0cd1};
          ep = C32K;
        end
        chk(rd, ex);
        chk({3'h0, tempBandwidthHz, internalRate, gyroBandwidthHz}, ex);
        chk({31'h0, lowpassActive}, {31'h0, b == 0});
        per(ep);
      end
    end
    $display("test filter table done");
    // overwrite policy: a full fifo keeps the newest sixteen entries
    bus(1'b1, 8'h1b, 8'h00);
    bus(1'b1, 8'h19, 8'hff);
    bus(1'b1, 8'h1a, 8'h00);
    repeat (800) @(posedge mclk);
    bus(1'b1, 8'h1a, 8'h06);
    repeat (200) @(posedge mclk);
    k = rawGyroZ;
    chk({16'h0, rateZData}, {16'h0, k - 16'h0001 + 16'hff05});
    chk({rateXData, rateYData}, {~(k - 16'h0001), (k - 16'h0001) ^ 16'h5a5a});
    chk({accelXData, accelYData}, {k + 16'h00ff, k + 16'h01ff});
    chk({16'h0, accelZData}, {16'h0, k + 16'h02ff});
    bus(1'b0, 8'h40, 8'h00);
    chk(rd & 32'h1f, 32'h10);
    bus(1'b0, 8'h41, 8'h00);
    chk(rd, {16'h0, k - 16'h0010 + 16'hff05});
    // drop policy: after refilling, later samples are discarded
    bus(1'b1, 8'h1a, 8'h40);
    repeat (200) @(posedge mclk);
    bus(1'b1, 8'h1a, 8'h46);
    repeat (200) @(posedge mclk);
    bus(1'b0, 8'h40, 8'h00);
    chk(rd & 32'h1f, 32'h10);
    bus(1'b0, 8'h41, 8'h00);
    chk(rd, {16'h0, k - 16'h000f + 16'hff05});
    $display("test fifo policy done");
    finish_test;
  end
endmodule : test_gyro_rate_filter_config
